/* design/spi_port_defs.vh */
`ifndef SPI_PORT_DEFS_VH
`define SPI_PORT_DEFS_VH
// Select mode field encodings.
`define SEL_MODE_3WIRE 2'h0
`define SEL_MODE_4WIRE_IN 2'h1
// Bit index of the upper select mode bit.
`define SEL_MODE_HI_BIT 1
// Clock divider default and reset value.
`define DIV_RESET 8'h00
// System clock period in ns and the fastest master bit rate in kHz.
`define SYS_PERIOD_NS 25
`define MAX_BIT_RATE_KHZ 12500
// Least system clock cycles per half serial clock period.
`define MIN_HALF_CYCLES ((1000000 / (`SYS_PERIOD_NS * `MAX_BIT_RATE_KHZ * 2)) + 1)
// Smallest divider setting: two cycles per half period keep the bit rate legal.
`define DIV_FLOOR 8'h01
// Byte length in bits.
`define BITS_PER_BYTE 4'h8
`define DATA_RESET 8'h00
`endif

/* design/sync_two_ff.v */
`timescale 1ns/1ps
// =====================================================================
// Two flip-flop synchroniser for pins from outside the clock domain.
module sync_two_ff #(
    parameter WIDTH = 3
) (
    input wire clk_sys_in,
    input wire nrst_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_ff;
    reg [WIDTH-1:0] stage2_ff;

    // The first stage feeds only the second stage.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage1_ff <= {WIDTH{1'b1}};
            stage2_ff <= {WIDTH{1'b1}};
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;
endmodule // sync_two_ff

/* design/byte_fifo.v */
`timescale 1ns/1ps
// =====================================================================
// Small synchronous FIFO with valid and ready on both sides.
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_sys_in,
    input wire nrst_in,
    input wire flush_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    wire do_wr;
    wire do_rd;

    // Handshakes; full and empty come from the occupancy count.
    assign in_ready_out = (count_ff != DEPTH[AW:0]);
    assign out_valid_out = (count_ff != {(AW+1){1'b0}});
    assign do_wr = in_valid_in && in_ready_out;
    assign do_rd = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr_ff];

    // Storage array written at the tail.
    always @(posedge clk_sys_in) begin
        if (do_wr) begin
            mem[wr_ptr_ff] <= in_data_in;
        end
    end

    // Pointers and count.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else if (flush_in) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_ff <= count_ff + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule // byte_fifo

/* design/serial_port_zero.v */
`timescale 1ns/1ps
`include "spi_port_defs.vh"
module serial_port_zero #(
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW = 2
) (
    input wire clk_sys_in,
    input wire nrst_in,
    input wire [7:0] port_data_wr_in,
    input wire port_data_wr_en_in,
    output reg [7:0] port_data_rd_out,
    input wire port_data_rd_en_in,
    input wire port_enable_bit_in,
    input wire port_enable_set_in,
    input wire master_enable_bit_in,
    input wire master_enable_set_in,
    input wire [1:0] select_mode_field_in,
    input wire clock_phase_bit_in,
    input wire clock_polarity_bit_in,
    input wire [7:0] clock_divider_in,
    input wire flags_clear_in,
    output reg port_enable_bit_out,
    output reg master_enable_bit_out,
    output reg transfer_done_flag_out,
    output reg write_collision_flag_out,
    output reg mode_fault_flag_out,
    output reg receive_overrun_flag_out,
    output wire busy_out,
    output wire rx_valid_out,
    output wire sck_out,
    output wire sck_oe_out,
    input wire sck_in,
    output wire mosi_out,
    output wire mosi_oe_out,
    input wire mosi_in,
    output wire miso_out,
    output wire miso_oe_out,
    input wire miso_in,
    output wire nss_out,
    output wire nss_oe_out,
    input wire nss_in
);
    // =================================================================
    // Pin synchronisers.
    wire [2:0] pins_sync;
    wire sck_s;
    wire mosi_s;
    wire nss_s;
    reg sck_d_ff;
    reg nss_d_ff;
    reg miso_d_ff;

    sync_two_ff #(.WIDTH(3)) u_sync (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .async_in({sck_in, mosi_in, nss_in}),
        .sync_out(pins_sync)
    );
    assign sck_s = pins_sync[2];
    assign mosi_s = pins_sync[1];
    assign nss_s = pins_sync[0];

    // =================================================================
    // Transmit buffer FIFO.
    wire tx_ready;
    wire tx_valid;
    wire [7:0] tx_data;
    reg tx_pop;
    wire wr_ok;

    assign wr_ok = port_data_wr_en_in && tx_ready;

    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txbuf (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .flush_in(!port_enable_bit_out),
        .in_valid_in(port_data_wr_en_in),
        .in_ready_out(tx_ready),
        .in_data_in(port_data_wr_in),
        .out_valid_out(tx_valid),
        .out_ready_in(tx_pop),
        .out_data_out(tx_data)
    );

    // =================================================================
    // Mode decode.
    wire is_master;
    wire is_slave;
    wire four_wire_in;
    wire selected;
    wire act_level;
    wire sck_rise;
    wire sck_fall;
    wire nss_fall;
    wire slave_edge_lead;
    wire slave_edge_trail;

    assign is_master = port_enable_bit_out && master_enable_bit_out;
    assign is_slave = port_enable_bit_out && !master_enable_bit_out;
    assign four_wire_in = (select_mode_field_in == `SEL_MODE_4WIRE_IN);
    assign selected = (select_mode_field_in == `SEL_MODE_3WIRE) ||
                      (four_wire_in && !nss_s);
    assign sck_rise = sck_s && !sck_d_ff;
    assign sck_fall = !sck_s && sck_d_ff;
    assign nss_fall = !nss_s && nss_d_ff;
    // Leading edge goes toward the active level set by polarity.
    assign act_level = !clock_polarity_bit_in;
    assign slave_edge_lead = is_slave && selected &&
                             (act_level ? sck_rise : sck_fall);
    assign slave_edge_trail = is_slave && selected &&
                              (act_level ? sck_fall : sck_rise);

    // =================================================================
    // Shift engine state.
    reg [7:0] shift_ff;
    reg shift_full_ff;
    reg [3:0] bit_cnt_ff;
    reg [7:0] div_cnt_ff;
    reg sck_gen_ff;
    reg m_busy_ff;
    reg m_second_ff;
    reg [7:0] rx_buf_ff;
    reg rx_valid_ff;
    wire [7:0] div_eff;

    assign div_eff = (clock_divider_in < `DIV_FLOOR) ? `DIV_FLOOR : clock_divider_in;

    // Sample edge selection from phase bit.
    wire s_sample;
    assign s_sample = clock_phase_bit_in ? slave_edge_trail : slave_edge_lead;

    // Transmit buffer pop: shifter empty, or a slave byte end reloads.
    wire byte_end_s;
    wire byte_end_m;
    wire m_tick;
    assign byte_end_s = s_sample && (bit_cnt_ff == `BITS_PER_BYTE - 4'h1);
    assign m_tick = m_busy_ff && (div_cnt_ff == div_eff);
    assign byte_end_m = m_tick && m_second_ff && (bit_cnt_ff == `BITS_PER_BYTE - 4'h1);

    always @* begin
        tx_pop = 1'b0;
        if (tx_valid && port_enable_bit_out) begin
            if (is_master) begin
                tx_pop = !m_busy_ff;
            end else begin
                tx_pop = !shift_full_ff || byte_end_s;
            end
        end
    end

    // Master sample/shift edge: first half edge is leading.
    wire m_lead;
    wire m_trail;
    assign m_lead = m_tick && !m_second_ff;
    assign m_trail = m_tick && m_second_ff;
    wire m_sample;
    wire m_shift;
    assign m_sample = clock_phase_bit_in ? m_trail : m_lead;
    assign m_shift = clock_phase_bit_in ? (m_lead && bit_cnt_ff != 4'h0) : m_trail;
    reg m_rx_bit_ff;

    // Shift register, bit counter and master clock generator.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shift_ff <= `DATA_RESET;
            shift_full_ff <= 1'b0;
            bit_cnt_ff <= 4'h0;
            div_cnt_ff <= `DIV_RESET;
            sck_gen_ff <= 1'b0;
            m_busy_ff <= 1'b0;
            m_second_ff <= 1'b0;
            m_rx_bit_ff <= 1'b0;
        end else if (!port_enable_bit_out) begin
            bit_cnt_ff <= 4'h0;
            shift_full_ff <= 1'b0;
            m_busy_ff <= 1'b0;
            m_second_ff <= 1'b0;
            div_cnt_ff <= `DIV_RESET;
            sck_gen_ff <= 1'b0;
        end else if (is_master) begin
            if (tx_pop) begin
                shift_ff <= tx_data;
                shift_full_ff <= 1'b1;
                m_busy_ff <= 1'b1;
                bit_cnt_ff <= 4'h0;
                div_cnt_ff <= `DIV_RESET;
                m_second_ff <= 1'b0;
            end else if (m_busy_ff) begin
                div_cnt_ff <= m_tick ? `DIV_RESET : div_cnt_ff + 8'h01;
                if (m_tick) begin
                    sck_gen_ff <= !sck_gen_ff;
                    m_second_ff <= !m_second_ff;
                end
                if (m_sample) begin
                    m_rx_bit_ff <= miso_d_ff;
                end
                // MSB first in; phase one moves data on the leading edge.
                if (m_shift) begin
                    shift_ff <= {shift_ff[6:0], m_rx_bit_ff};
                end
                if (m_trail) begin
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end
                if (byte_end_m) begin
                    m_busy_ff <= 1'b0;
                    shift_full_ff <= 1'b0;
                    bit_cnt_ff <= 4'h0;
                end
            end
        end else begin
            if (four_wire_in && nss_fall) begin
                bit_cnt_ff <= 4'h0;
            end else if (s_sample) begin
                shift_ff <= {shift_ff[6:0], mosi_s};
                bit_cnt_ff <= byte_end_s ? 4'h0 : bit_cnt_ff + 4'h1;
                if (byte_end_s) begin
                    shift_full_ff <= 1'b0;
                end
            end
            if (tx_pop) begin
                shift_ff <= tx_data;
                shift_full_ff <= 1'b1;
            end
        end
    end

    // Registered MISO and edge history for the synchronised clock and select pins.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            // Matches the synchroniser reset so no false edge follows reset.
            sck_d_ff <= 1'b1;
            nss_d_ff <= 1'b1;
            miso_d_ff <= 1'b0;
        end else begin
            sck_d_ff <= sck_s;
            nss_d_ff <= nss_s;
            miso_d_ff <= miso_in;
        end
    end

    // =================================================================
    // Receive buffer, control bits and flags; hardware set wins over clear.
    wire byte_done;
    wire [7:0] byte_in;
    wire fault;
    assign byte_done = byte_end_m || (is_slave && byte_end_s);
    assign byte_in = byte_end_m ? {shift_ff[6:0], (clock_phase_bit_in ? miso_d_ff : m_rx_bit_ff)}
                                : {shift_ff[6:0], mosi_s};
    assign fault = is_master && four_wire_in && nss_fall;

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_buf_ff <= `DATA_RESET;
            rx_valid_ff <= 1'b0;
            port_data_rd_out <= `DATA_RESET;
            port_enable_bit_out <= 1'b0;
            master_enable_bit_out <= 1'b0;
            transfer_done_flag_out <= 1'b0;
            write_collision_flag_out <= 1'b0;
            mode_fault_flag_out <= 1'b0;
            receive_overrun_flag_out <= 1'b0;
        end else begin
            if (port_enable_set_in) begin
                port_enable_bit_out <= port_enable_bit_in;
            end
            if (master_enable_set_in) begin
                master_enable_bit_out <= master_enable_bit_in;
            end
            if (port_data_rd_en_in) begin
                port_data_rd_out <= rx_buf_ff;
                rx_valid_ff <= 1'b0;
            end
            if (flags_clear_in) begin
                transfer_done_flag_out <= 1'b0;
                write_collision_flag_out <= 1'b0;
                mode_fault_flag_out <= 1'b0;
                receive_overrun_flag_out <= 1'b0;
            end
            if (byte_done) begin
                transfer_done_flag_out <= 1'b1;
                if (rx_valid_ff && !port_data_rd_en_in && is_slave) begin
                    receive_overrun_flag_out <= 1'b1;
                end else begin
                    rx_buf_ff <= byte_in;
                    rx_valid_ff <= 1'b1;
                end
            end
            if (port_data_wr_en_in && !wr_ok) begin
                write_collision_flag_out <= 1'b1;
            end
            if (fault) begin
                mode_fault_flag_out <= 1'b1;
                master_enable_bit_out <= 1'b0;
                port_enable_bit_out <= 1'b0;
            end
        end
    end

    // =================================================================
    // Pin drivers.
    // master data out
    assign mosi_out = shift_ff[7];
    assign mosi_oe_out = is_master;
    assign sck_out = sck_gen_ff ^ clock_polarity_bit_in;
    assign sck_oe_out = is_master;
    assign miso_out = shift_ff[7];
    assign miso_oe_out = is_slave && selected;
    assign nss_out = select_mode_field_in[0];
    assign nss_oe_out = select_mode_field_in[`SEL_MODE_HI_BIT] && port_enable_bit_out;
    assign busy_out = m_busy_ff || (is_slave && bit_cnt_ff != 4'h0);
    assign rx_valid_out = rx_valid_ff;
endmodule // serial_port_zero

/* bench/spi_port_checker.sv */
`timescale 1ns/1ps
// ==========================================================
// Checker on the serial port pins, control bits and flags.
module spi_port_checker (
    input wire clk_sys_in,
    input wire nrst_in,
    input wire port_data_wr_en_in,
    input wire [1:0] select_mode_field_in,
    input wire nss_in,
    input wire port_enable_bit_out,
    input wire master_enable_bit_out,
    input wire transfer_done_flag_out,
    input wire write_collision_flag_out,
    input wire mode_fault_flag_out,
    input wire receive_overrun_flag_out,
    input wire rx_valid_out,
    input wire sck_out,
    input wire sck_oe_out,
    input wire miso_oe_out,
    input wire nss_out,
    input wire nss_oe_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    // Slave operation is an enabled port that is not a master.
    wire slave_on = port_enable_bit_out && !master_enable_bit_out;
    chk_miso_off_disabled: assert property (!port_enable_bit_out && $past(!port_enable_bit_out) |-> !miso_oe_out)
        else $error("slave data out driven while port disabled");
    chk_miso_on_3wire: assert property ((slave_on && select_mode_field_in == 2'h0) [*3] |-> miso_oe_out)
        else $error("three-wire slave not driving data out");
    chk_sel_out_level: assert property ((port_enable_bit_out && select_mode_field_in[1] && $stable(select_mode_field_in)) [*3] |-> nss_oe_out && nss_out == select_mode_field_in[0])
        else $error("select output not equal to lower mode bit");
    chk_slave_no_clock: assert property ((!master_enable_bit_out) [*2] |-> !sck_oe_out)
        else $error("serial clock driven outside master operation");
    chk_fault_clears: assert property ($rose(mode_fault_flag_out) |-> !master_enable_bit_out && !port_enable_bit_out)
        else $error("mode fault left an enable bit set");
    chk_collision_cause: assert property ($rose(write_collision_flag_out) |-> $past(port_data_wr_en_in))
        else $error("collision flag rose without a data write");
    chk_overrun_cause: assert property ($rose(receive_overrun_flag_out) |-> $past(rx_valid_out) && !master_enable_bit_out)
        else $error("overrun flag rose without unread slave data");
    chk_clock_rate: assert property (sck_oe_out && $past(sck_oe_out) && $changed(sck_out) |=> $stable(sck_out) || !sck_oe_out)
        else $error("serial clock half period shorter than two cycles");
    chk_deselect_idle: assert property (nss_in [*6] ##0 (slave_on && select_mode_field_in == 2'h1) |-> !$rose(transfer_done_flag_out))
        else $error("deselected slave completed a byte");
    cover property ($rose(transfer_done_flag_out) && master_enable_bit_out);
    cover property ($rose(transfer_done_flag_out) && slave_on);
    cover property ($rose(mode_fault_flag_out));
endmodule // spi_port_checker
bind serial_port_zero spi_port_checker chk_inst (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .port_data_wr_en_in(port_data_wr_en_in),
    .select_mode_field_in(select_mode_field_in), .nss_in(nss_in),
    .port_enable_bit_out(port_enable_bit_out), .master_enable_bit_out(master_enable_bit_out),
    .transfer_done_flag_out(transfer_done_flag_out),
    .write_collision_flag_out(write_collision_flag_out),
    .mode_fault_flag_out(mode_fault_flag_out),
    .receive_overrun_flag_out(receive_overrun_flag_out), .rx_valid_out(rx_valid_out),
    .sck_out(sck_out), .sck_oe_out(sck_oe_out), .miso_oe_out(miso_oe_out),
    .nss_out(nss_out), .nss_oe_out(nss_oe_out)
);

/* bench/spi_far_end.sv */
`timescale 1ns/1ps
// ==========================================================
// Far end of the bus: a slave answering the port, or a master driving it.
module spi_far_end (
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    output logic sck_out,
    output logic mosi_out,
    output logic nss_out,
    output logic miso_out
);
    logic [7:0] tx_ff = 8'h00;
    logic [7:0] rx_ff = 8'h00;
    logic [2:0] bit_ff = 3'h0;
    logic armed_ff = 1'b0;
    int byte_cnt = 0;
    // The clock stands still low and the select high outside frames.
    initial begin
        sck_out = 1'b0;
        mosi_out = 1'b1;
        nss_out = 1'b1;
    end
    assign miso_out = tx_ff[7];
    // ==========================================================
    // Slave side
    // Mode zero sampling.
    always @(posedge sck_in) begin
        rx_ff <= {rx_ff[6:0], mosi_in};
        armed_ff <= 1'b1;
        bit_ff <= bit_ff + 3'h1;
        if (bit_ff == 3'h7) begin
            byte_cnt <= byte_cnt + 1;
        end
    end
    // Next bit on falling edge, only once a bit was sampled (modes 0 and 3).
    always @(negedge sck_in) begin
        if (armed_ff) begin
            tx_ff <= {tx_ff[6:0], ~tx_ff[0]};
        end
    end
    // Preloads the byte returned to the port.
    task automatic load(input logic [7:0] b);
        tx_ff = b;
        armed_ff = 1'b0;
    endtask
    // Drives the select line by hand.
    task automatic sel_level(input logic v);
        nss_out = v;
    endtask
    // ==========================================================
    // Master side
    // Select leads clock.
    task automatic xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
        // Start off the system clock edge so no pin moves on a sampling edge.
        #5 nss_out = ~sel;
        #100;
        for (int i = 7; i >= 0; i--) begin
            mosi_out = tx[i];
            #100 sck_out = 1'b1;
            rx[i] = miso_in;
            #100 sck_out = 1'b0;
        end
        #100 nss_out = 1'b1;
        mosi_out = ~mosi_out;
        // Select stays high long enough to be seen between bytes.
        #100;
    endtask
endmodule // spi_far_end

/* bench/tb.sv */
`timescale 1ns/1ps
// ==========================================================
// Testbench for the serial port: control tasks and directed tests.
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] div = 8'h01;
    logic [7:0] rd, got;
    logic [1:0] mode = 2'h0;
    logic cpol = 1'b0, cpha = 1'b0;
    logic we = 0, re = 0, pe = 0, pe_set = 0, me = 0, me_set = 0, clr = 0;
    logic pe_o, me_o, done_f, write_collision_flag_f, mode_fault_flag_f, ovr_f, busy, rxv;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, nss_o, nss_oe;
    logic f_sck, f_mosi, f_nss, f_miso;
    int fail_count = 0;
    int cmp_count = 0;
    int base;
    // Each wire takes the level of whichever party drives it.
    wire sck_w = sck_oe ? sck_o : f_sck;
    wire mosi_w = mosi_oe ? mosi_o : f_mosi;
    wire miso_w = miso_oe ? miso_o : f_miso;
    wire nss_w = nss_oe ? nss_o : f_nss;
    initial forever #12.5 clk = ~clk;
    serial_port_zero serial_port_zero_inst (
        .clk_sys_in(clk), .nrst_in(rst_n), .port_data_wr_in(wd), .port_data_wr_en_in(we),
        .port_data_rd_out(rd), .port_data_rd_en_in(re), .port_enable_bit_in(pe),
        .port_enable_set_in(pe_set), .master_enable_bit_in(me), .master_enable_set_in(me_set),
        .select_mode_field_in(mode), .clock_phase_bit_in(cpha), .clock_polarity_bit_in(cpol),
        .clock_divider_in(div), .flags_clear_in(clr), .port_enable_bit_out(pe_o),
        .master_enable_bit_out(me_o), .transfer_done_flag_out(done_f),
        .write_collision_flag_out(write_collision_flag_f), .mode_fault_flag_out(mode_fault_flag_f),
        .receive_overrun_flag_out(ovr_f), .busy_out(busy), .rx_valid_out(rxv),
        .sck_out(sck_o), .sck_oe_out(sck_oe), .sck_in(sck_w), .mosi_out(mosi_o),
        .mosi_oe_out(mosi_oe), .mosi_in(mosi_w), .miso_out(miso_o), .miso_oe_out(miso_oe),
        .miso_in(miso_w), .nss_out(nss_o), .nss_oe_out(nss_oe), .nss_in(nss_w)
    );
    spi_far_end spi_far_end_inst (
        .sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w),
        .sck_out(f_sck), .mosi_out(f_mosi), .nss_out(f_nss), .miso_out(f_miso)
    );
    // ==========================================================
    // Tasks
    task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask
    task automatic ctl(input logic p, input logic m);
        @(posedge clk);
        pe <= p;
        me <= m;
        pe_set <= 1'b1;
        me_set <= 1'b1;
        @(posedge clk);
        pe_set <= 1'b0;
        me_set <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic set_mode(input logic [1:0] m);
        @(posedge clk);
        mode <= m;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd_byte();
        @(posedge clk);
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        got = rd;
    endtask
    task automatic pulse_clr();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        #1;
    endtask
    // Waits a bounded time for the done flag, checks it, then clears flags.
    task automatic wait_done();
        for (int i = 0; i < 2000 && done_f !== 1'b1; i++) @(posedge clk);
        #1;
        check({7'h0, done_f}, 8'h01, "done flag");
        pulse_clr();
    endtask
    task automatic results();
        $display("compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check({pe_o, me_o, done_f, write_collision_flag_f, mode_fault_flag_f, ovr_f, miso_oe, nss_oe}, 8'h00, "reset");
        $display("test reset finished");
        spi_far_end_inst.load(8'h3c);
        ctl(1'b1, 1'b1);
        check({4'h0, pe_o, me_o, mosi_oe, sck_oe}, 8'h0f, "master enable");
        wr(8'ha5);
        wait_done();
        check(spi_far_end_inst.rx_ff, 8'ha5, "master out");
        rd_byte();
        check(got, 8'h3c, "master in");
        check({6'h0, busy, rxv}, 8'h00, "idle after read");
        check({7'h0, nss_oe}, 8'h00, "select unrouted");
        $display("test master byte finished");
        base = spi_far_end_inst.byte_cnt;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            we <= 1'b1;
            wd <= 8'h10 + 8'(i);
        end
        @(posedge clk);
        we <= 1'b0;
        #1;
        check({7'h0, write_collision_flag_f}, 8'h01, "collision");
        pulse_clr();
        for (int i = 0; i < 4000 && spi_far_end_inst.byte_cnt < base + 5; i++) @(posedge clk);
        wait_done();
        check(8'(spi_far_end_inst.byte_cnt - base), 8'h05, "queued bytes");
        check(spi_far_end_inst.rx_ff, 8'h14, "last kept byte");
        $display("test collision finished");
        ctl(1'b0, 1'b0);
        @(posedge clk);
        cpol <= 1'b1;
        cpha <= 1'b1;
        ctl(1'b1, 1'b1);
        spi_far_end_inst.load(8'hc5);
        wr(8'h4b);
        wait_done();
        check(spi_far_end_inst.rx_ff, 8'h4b, "mode three out");
        rd_byte();
        check(got, 8'hc5, "mode three in");
        ctl(1'b0, 1'b0);
        @(posedge clk);
        cpol <= 1'b0;
        cpha <= 1'b0;
        ctl(1'b1, 1'b1);
        $display("test clock mode three finished");
        set_mode(2'h3);
        check({6'h0, nss_oe, nss_o}, 8'h03, "select high");
        set_mode(2'h2);
        check({6'h0, nss_oe, nss_o}, 8'h02, "select low");
        set_mode(2'h1);
        spi_far_end_inst.sel_level(1'b0);
        repeat (8) @(posedge clk);
        #1;
        check({5'h0, mode_fault_flag_f, me_o, pe_o}, 8'h04, "mode fault");
        spi_far_end_inst.sel_level(1'b1);
        pulse_clr();
        $display("test select modes finished");
        ctl(1'b1, 1'b0);
        rd_byte();
        wr(8'h96);
        spi_far_end_inst.xfer(8'h5a, 1'b1, got);
        check(got, 8'h96, "slave out");
        wait_done();
        check({7'h0, rxv}, 8'h01, "unread byte");
        rd_byte();
        check(got, 8'h5a, "slave in");
        spi_far_end_inst.xfer(8'hc3, 1'b1, got);
        spi_far_end_inst.xfer(8'h77, 1'b1, got);
        repeat (8) @(posedge clk);
        #1;
        check({7'h0, ovr_f}, 8'h01, "overrun");
        rd_byte();
        check(got, 8'hc3, "kept byte");
        pulse_clr();
        spi_far_end_inst.xfer(8'h11, 1'b0, got);
        repeat (8) @(posedge clk);
        #1;
        check({6'h0, done_f, miso_oe}, 8'h00, "deselected");
        $display("test four-wire slave finished");
        ctl(1'b0, 1'b0);
        // The far end is the only master on the three-wire bus.
        set_mode(2'h0);
        ctl(1'b1, 1'b0);
        check({7'h0, miso_oe}, 8'h01, "three-wire drive");
        spi_far_end_inst.xfer(8'he7, 1'b0, got);
        wait_done();
        rd_byte();
        check(got, 8'he7, "three-wire in");
        $display("test three-wire slave finished");
        results();
    end
    // Cuts a hang short well after the tests should have ended.
    initial begin
        #2000000;
        fail_count++;
        $display("[FAIL] %0t: watchdog expired", $time);
        results();
    end
endmodule // tb
